// ==== design/slre_top.sv ====
// Summary of operation
// - length op counts bytes from head word up to first zero byte, writes count.
// - length result is one 16-bit word holding bytes, not words.
// - every byte counts one, so a two-byte character adds two.
// - a failure sets the shared error flag and writes the error code word.
// - length op fails with 6706 when no zero byte before memory end.
// - length op fails with 6706 when length reaches 32768 bytes or more.
// - right extract copies last n source bytes, in order, to destination head.
// - right extract source is bytes from head up to first zero byte.
// - n of zero writes an all-zero word to the destination head.
// - right extract appends a zero byte after the last copied byte.
// - odd count puts the zero byte in the upper byte of the last word.
// - even count writes an all-zero word after the last copied word.
// - right extract fails with 6706 when n exceeds the source length.
// - right extract fails with 6706 when n is negative.
`timescale 1ns/1ps
module slre_top (
  input  wire logic             mclk_i,
  input  wire logic             resetn_i,
  input  wire logic             en_i,
  input  wire logic             pulse_form_i,
  input  wire slre_pkg::slre_op_t op_sel_i,
  input  wire logic [15:0]      src_head_i,
  input  wire logic [15:0]      dst_head_i,
  input  wire logic [15:0]      count_n_i,
  input  wire logic             error_clear_i,
  input  wire logic [15:0]      mem_rdata_i,
  output logic      [15:0]      mem_addr_o,
  output logic                  mem_rd_o,
  output logic                  mem_wr_o,
  output logic      [15:0]      mem_wdata_o,
  output logic                  eno_o,
  output logic                  busy_o,
  output logic                  done_o,
  output logic                  operation_error_flag_o,
  output logic      [15:0]      operation_error_code_word_o
);
  import slre_pkg::*;

  slre_state_t state_reg;
  slre_op_t    op_reg;
  logic [15:0] src_reg;
  logic [15:0] dst_reg;
  logic [15:0] n_reg;
  logic [15:0] widx_reg;
  logic [15:0] len_reg;
  logic [15:0] oidx_reg;
  logic [7:0]  lo_byte_reg;
  logic        last_wr_reg;
  logic        en_d_reg;
  logic        done_reg;
  logic        err_flag_reg;
  logic [15:0] err_code_reg;
  logic [15:0] addr_reg;
  logic        rd_reg;
  logic        wr_reg;
  logic [15:0] wdata_reg;

  // ****************************************************************
  // combinational helpers
  // ****************************************************************
  logic        start;
  logic        lo_zero;
  logic        hi_zero;
  logic [16:0] found_len;
  logic [16:0] next_span;
  logic [15:0] src_pos;
  logic [7:0]  pick_byte;
  logic [16:0] dst_end;
  logic [15:0] oidx_next;

  // pulse form needs a fresh rising edge; a rise during a run is dropped
  assign start = (state_reg == SLRE_S_IDLE) &&
                 (pulse_form_i ? (en_i && !en_d_reg) : en_i);
  assign lo_zero   = mem_rdata_i[SLRE_LO_LSB +: SLRE_BYTE_W] == SLRE_TERM_BYTE;
  assign hi_zero   = mem_rdata_i[SLRE_HI_LSB +: SLRE_BYTE_W] == SLRE_TERM_BYTE;
  // two bytes per word, each byte one unit
  assign found_len = {widx_reg, 1'b0} + {16'h0000, !lo_zero};
  assign next_span = {widx_reg + 16'h0001, 1'b0};
  assign src_pos   = len_reg - n_reg + oidx_reg;
  assign pick_byte = src_pos[0] ? mem_rdata_i[SLRE_HI_LSB +: SLRE_BYTE_W]
                                : mem_rdata_i[SLRE_LO_LSB +: SLRE_BYTE_W];
  assign dst_end   = {1'b0, dst_reg} + {2'b00, n_reg[15:1]};
  assign oidx_next = oidx_reg + 16'h0001;

  // ****************************************************************
  // trigger edge and execution state
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      en_d_reg <= 1'b0;
      eno_o    <= 1'b0;
    end else begin
      en_d_reg <= en_i;
      eno_o    <= en_i;
    end
  end

  // ****************************************************************
  // sequencer and memory port
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      state_reg   <= SLRE_S_IDLE;
      op_reg      <= SLRE_OP_LENGTH;
      src_reg     <= 16'h0000;
      dst_reg     <= 16'h0000;
      n_reg       <= 16'h0000;
      widx_reg    <= 16'h0000;
      len_reg     <= 16'h0000;
      oidx_reg    <= 16'h0000;
      lo_byte_reg <= 8'h00;
      last_wr_reg <= 1'b0;
      addr_reg    <= 16'h0000;
      rd_reg      <= 1'b0;
      wr_reg      <= 1'b0;
      wdata_reg   <= SLRE_NULL_WORD;
    end else begin
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
      unique case (state_reg)
        SLRE_S_IDLE: begin
          if (start) begin
            op_reg    <= op_sel_i;
            src_reg   <= src_head_i;
            dst_reg   <= dst_head_i;
            n_reg     <= count_n_i;
            widx_reg  <= 16'h0000;
            oidx_reg  <= 16'h0000;
            addr_reg  <= src_head_i;
            rd_reg    <= 1'b1;
            state_reg <= SLRE_S_SCAN_RD;
          end
        end
        SLRE_S_SCAN_RD: state_reg <= SLRE_S_SCAN_DAT;
        SLRE_S_SCAN_DAT: begin
          if (lo_zero || hi_zero) begin
            if (found_len >= SLRE_LEN_LIMIT) begin
              state_reg <= SLRE_S_FAIL;
            end else if (op_reg == SLRE_OP_LENGTH) begin
              len_reg     <= found_len[15:0];
              addr_reg    <= dst_reg;
              wdata_reg   <= found_len[15:0];
              wr_reg      <= 1'b1;
              last_wr_reg <= 1'b1;
              state_reg   <= SLRE_S_WRITE;
            end else begin
              len_reg   <= found_len[15:0];
              state_reg <= SLRE_S_CHECK;
            end
          end else if ((src_reg + widx_reg) == SLRE_MEM_LAST) begin
            state_reg <= SLRE_S_FAIL;
          end else if (next_span >= SLRE_LEN_LIMIT) begin
            state_reg <= SLRE_S_FAIL;
          end else begin
            widx_reg  <= widx_reg + 16'h0001;
            addr_reg  <= src_reg + widx_reg + 16'h0001;
            rd_reg    <= 1'b1;
            state_reg <= SLRE_S_SCAN_RD;
          end
        end
        SLRE_S_CHECK: begin
          // every check precedes the first write, so a failure leaves dst alone
          if (n_reg[15]) begin
            state_reg <= SLRE_S_FAIL;
          end else if (n_reg > len_reg) begin
            state_reg <= SLRE_S_FAIL;
          end else if (dst_end > {1'b0, SLRE_MEM_LAST}) begin
            state_reg <= SLRE_S_FAIL;
          end else if (n_reg == 16'h0000) begin
            addr_reg    <= dst_reg;
            wdata_reg   <= SLRE_NULL_WORD;
            wr_reg      <= 1'b1;
            last_wr_reg <= 1'b1;
            state_reg   <= SLRE_S_WRITE;
          end else begin
            addr_reg  <= src_reg + {1'b0, src_pos[15:1]};
            rd_reg    <= 1'b1;
            state_reg <= SLRE_S_COPY_RD;
          end
        end
        SLRE_S_COPY_RD: state_reg <= SLRE_S_COPY_DAT;
        SLRE_S_COPY_DAT: begin
          oidx_reg <= oidx_next;
          if (oidx_reg[0]) begin
            addr_reg    <= dst_reg + {1'b0, oidx_reg[15:1]};
            wdata_reg   <= {pick_byte, lo_byte_reg};
            wr_reg      <= 1'b1;
            last_wr_reg <= 1'b0;
            state_reg   <= SLRE_S_WRITE;
          end else if (oidx_next == n_reg) begin
            addr_reg    <= dst_reg + {1'b0, oidx_reg[15:1]};
            wdata_reg   <= {SLRE_TERM_BYTE, pick_byte};
            wr_reg      <= 1'b1;
            last_wr_reg <= 1'b1;
            state_reg   <= SLRE_S_WRITE;
          end else begin
            lo_byte_reg <= pick_byte;
            addr_reg    <= src_reg + {1'b0, src_pos[15:1]} + {15'h0000, src_pos[0]};
            rd_reg      <= 1'b1;
            state_reg   <= SLRE_S_COPY_RD;
          end
        end
        SLRE_S_WRITE: begin
          if (last_wr_reg) begin
            state_reg <= SLRE_S_DONE;
          end else if (oidx_reg == n_reg) begin
            addr_reg    <= dst_reg + {1'b0, n_reg[15:1]};
            wdata_reg   <= SLRE_NULL_WORD;
            wr_reg      <= 1'b1;
            last_wr_reg <= 1'b1;
            state_reg   <= SLRE_S_WRITE;
          end else begin
            addr_reg  <= src_reg + {1'b0, src_pos[15:1]};
            rd_reg    <= 1'b1;
            state_reg <= SLRE_S_COPY_RD;
          end
        end
        SLRE_S_FAIL: state_reg <= SLRE_S_DONE;
        SLRE_S_DONE: state_reg <= SLRE_S_IDLE;
      endcase
    end
  end

  assign mem_addr_o  = addr_reg;
  assign mem_rd_o    = rd_reg;
  assign mem_wr_o    = wr_reg;
  assign mem_wdata_o = wdata_reg;

  // ****************************************************************
  // run status
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      busy_o   <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      busy_o   <= start || (state_reg != SLRE_S_IDLE && state_reg != SLRE_S_DONE);
      done_reg <= (state_reg == SLRE_S_DONE);
    end
  end
  assign done_o = done_reg;

  // ****************************************************************
  // shared error flag and code word
  // ****************************************************************
  // a failure in the same cycle as a clear keeps the flag set
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      err_flag_reg <= 1'b0;
      err_code_reg <= SLRE_CODE_RST;
    end else if (state_reg == SLRE_S_FAIL) begin
      err_flag_reg <= 1'b1;
      err_code_reg <= SLRE_ERR_STRING;
    end else if (error_clear_i) begin
      err_flag_reg <= 1'b0;
    end
  end
  assign operation_error_flag_o      = err_flag_reg;
  assign operation_error_code_word_o = err_code_reg;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  a_err_report: assert property (state_reg == SLRE_S_FAIL |=> operation_error_flag_o &&
      operation_error_code_word_o == SLRE_ERR_STRING) else $error("error not reported");
  a_fail_nowrite: assert property (state_reg == SLRE_S_FAIL |-> !mem_wr_o &&
      $past(state_reg) != SLRE_S_WRITE) else $error("write on failing run");
  a_len_word: assert property (mem_wr_o && op_reg == SLRE_OP_LENGTH |-> mem_addr_o == dst_reg &&
      mem_wdata_o == len_reg && !mem_wdata_o[15]) else $error("bad length word");
  a_odd_term: assert property (mem_wr_o && last_wr_reg && op_reg == SLRE_OP_RIGHT && n_reg[0]
      |-> mem_wdata_o[SLRE_HI_LSB +: SLRE_BYTE_W] == SLRE_TERM_BYTE)
      else $error("odd end lacks zero byte");
  a_even_null: assert property (mem_wr_o && last_wr_reg && op_reg == SLRE_OP_RIGHT && !n_reg[0]
      |-> mem_wdata_o == SLRE_NULL_WORD && mem_addr_o == dst_reg + {1'b0, n_reg[15:1]})
      else $error("even end lacks null word");
  a_neg_count: assert property (state_reg == SLRE_S_CHECK && n_reg[15]
      |=> state_reg == SLRE_S_FAIL ##1 operation_error_flag_o)
      else $error("negative count accepted");
  a_over_count: assert property (state_reg == SLRE_S_CHECK && !n_reg[15] && n_reg > len_reg
      |=> state_reg == SLRE_S_FAIL) else $error("count above length accepted");
  a_pulse_once: assert property (state_reg == SLRE_S_IDLE && pulse_form_i && en_i && en_d_reg
      |=> state_reg == SLRE_S_IDLE) else $error("pulse form rerun");
  a_cont_rerun: assert property (state_reg == SLRE_S_IDLE && !pulse_form_i && en_i
      |=> state_reg == SLRE_S_SCAN_RD ##1 mem_rd_o == 1'b0) else $error("continuous not run");
  a_set_wins: assert property (state_reg == SLRE_S_FAIL && error_clear_i
      |=> operation_error_flag_o) else $error("clear beat set");

endmodule

// ==== common/slre_pkg.sv ====
package slre_pkg;

  // ****************************************************************
  // data layout
  // ****************************************************************
  localparam int          SLRE_BYTE_W     = 8;
  localparam int          SLRE_LO_LSB     = 0;      // lower string position
  localparam int          SLRE_HI_LSB     = 8;      // next string position
  localparam logic [7:0]  SLRE_TERM_BYTE  = 8'h00;
  localparam logic [15:0] SLRE_NULL_WORD  = 16'h0000;

  // ****************************************************************
  // limits, error code and reset values
  // ****************************************************************
  localparam logic [15:0] SLRE_MEM_LAST   = 16'hFFFF; // last word address
  localparam logic [16:0] SLRE_LEN_LIMIT  = 17'h08000; // 32768 bytes
  localparam logic [15:0] SLRE_ERR_STRING = 16'h1A32;  // decimal 6706
  localparam logic [15:0] SLRE_CODE_RST   = 16'h0000;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic {
    SLRE_OP_LENGTH,
    SLRE_OP_RIGHT
  } slre_op_t;

  typedef enum logic [3:0] {
    SLRE_S_IDLE,
    SLRE_S_SCAN_RD,
    SLRE_S_SCAN_DAT,
    SLRE_S_CHECK,
    SLRE_S_COPY_RD,
    SLRE_S_COPY_DAT,
    SLRE_S_WRITE,
    SLRE_S_FAIL,
    SLRE_S_DONE
  } slre_state_t;

endpackage

// ==== test/slre_mem_model.sv ====
`timescale 1ns/1ps
module slre_mem_model (
  input  wire logic        mclk_i,
  input  wire logic [15:0] mem_addr_i,
  input  wire logic        mem_rd_i,
  input  wire logic        mem_wr_i,
  input  wire logic [15:0] mem_wdata_i,
  output logic      [15:0] mem_rdata_o
);
  logic [15:0] mem [0:65535];

  // ****************************************************************
  // word store with one-cycle read answer
  // ****************************************************************
  initial begin
    mem_rdata_o = 16'h0000;
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 16'h0000;
    end
  end

  // data is only valid the cycle after a strobe; otherwise it toggles so stale reads show
  always @(posedge mclk_i) begin
    if (mem_wr_i) begin
      mem[mem_addr_i] <= mem_wdata_i;
    end
    if (mem_rd_i) begin
      mem_rdata_o <= mem[mem_addr_i];
    end else begin
      mem_rdata_o <= ~mem_rdata_o;
    end
  end
endmodule

// ==== test/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import slre_pkg::*;
  logic mclk_i = 0, resetn_i = 0, en = 0, pform = 1, eclr = 0;
  slre_op_t op = SLRE_OP_LENGTH;
  logic [15:0] src = 0, dst = 0, cnt = 0, rdata, addr, wdata;
  logic rd, wr, eno, busy, done, eflag;
  logic [15:0] ecode;
  int n_mismatch = 0, num_checks = 0, cyc = 0, ndone;
  typedef struct { slre_op_t op; logic [15:0] s, n, e0, e1, e2; } slre_row_t;
  slre_row_t rows [8] = '{
    '{SLRE_OP_LENGTH, 16'h0010, 16'h0000, 16'h000B, 16'hEEEE, 16'hEEEE},
    '{SLRE_OP_LENGTH, 16'h0020, 16'h0000, 16'h0002, 16'hEEEE, 16'hEEEE},
    '{SLRE_OP_LENGTH, 16'h0030, 16'h0000, 16'h0000, 16'hEEEE, 16'hEEEE},
    '{SLRE_OP_RIGHT,  16'h0010, 16'h0005, 16'h3231, 16'h3433, 16'h0035},
    '{SLRE_OP_RIGHT,  16'h0010, 16'h0004, 16'h3332, 16'h3534, 16'h0000},
    '{SLRE_OP_RIGHT,  16'h0010, 16'h0000, 16'h0000, 16'hEEEE, 16'hEEEE},
    '{SLRE_OP_RIGHT,  16'h0010, 16'h0001, 16'h0035, 16'hEEEE, 16'hEEEE},
    '{SLRE_OP_RIGHT,  16'h0010, 16'h0006, 16'h3146, 16'h3332, 16'h3534}};

  slre_top dut_u (.mclk_i(mclk_i), .resetn_i(resetn_i), .en_i(en), .pulse_form_i(pform),
    .op_sel_i(op), .src_head_i(src), .dst_head_i(dst), .count_n_i(cnt),
    .error_clear_i(eclr), .mem_rdata_i(rdata), .mem_addr_o(addr), .mem_rd_o(rd),
    .mem_wr_o(wr), .mem_wdata_o(wdata), .eno_o(eno), .busy_o(busy), .done_o(done),
    .operation_error_flag_o(eflag), .operation_error_code_word_o(ecode));
  slre_mem_model mem_u (.mclk_i(mclk_i), .mem_addr_i(addr), .mem_rd_i(rd), .mem_wr_i(wr),
    .mem_wdata_i(wdata), .mem_rdata_o(rdata));

  // ****************************************************************
  // clock, timeout and shared tasks
  // ****************************************************************
  always #20 mclk_i = ~mclk_i;

  // the length-limit scan alone takes about 33k cycles; the ceiling leaves a wide margin
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 95000) begin
      n_mismatch++;
      $display("Error at %0t: run did not finish", $time);
      wrap_up();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // one pulse-form run; destination preset so untouched words stay visible
  // a hung run is caught by the global ceiling, which ends in the closing report
  task automatic run(input slre_op_t o, input logic [15:0] s, input logic [15:0] n,
                     input logic [15:0] d, input logic hold_clr);
    for (int i = 0; i < 4; i++) mem_u.mem[16'h0100 + i] = 16'hEEEE;
    @(posedge mclk_i);
    op <= o;
    src <= s;
    cnt <= n;
    dst <= d;
    eclr <= 1;
    en <= 1;
    @(posedge mclk_i);
    eclr <= hold_clr;
    @(posedge mclk_i);
    chk(16'(busy), 16'h0001);
    while (done !== 1'b1) begin
      @(posedge mclk_i);
    end
    en <= 0;
    eclr <= 0;
    @(posedge mclk_i);
    chk(16'(busy), 16'h0000);
  endtask

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    // preload after time zero so the model's own clearing cannot overwrite it
    repeat (3) @(posedge mclk_i);
    {mem_u.mem[16], mem_u.mem[17], mem_u.mem[18]} = {16'h4241, 16'h4443, 16'h4645};
    {mem_u.mem[19], mem_u.mem[20], mem_u.mem[21]} = {16'h3231, 16'h3433, 16'h0035};
    mem_u.mem[32] = 16'hA082;
    chk(16'({eflag, done, busy, rd, wr, eno}), 16'h0000);
    chk(ecode, 16'h0000);
    resetn_i <= 1;
    $display("reset test done");
    foreach (rows[i]) begin
      run(rows[i].op, rows[i].s, rows[i].n, 16'h0100, 1'b0);
      chk(mem_u.mem[256], rows[i].e0);
      chk(mem_u.mem[257], rows[i].e1);
      chk(mem_u.mem[258], rows[i].e2);
      chk(16'(eflag), 16'h0000);
    end
    $display("table tests done");
    // failures: n too big, n negative, no terminator before memory end, no room at dst
    // k 1 holds the clear high: the failure still sets the flag, then the clear drops it
    for (int k = 0; k < 4; k++) begin
      if (k == 2) for (int i = 16'hFFF0; i < 65536; i++) mem_u.mem[i] = 16'h3131;
      run(k == 2 ? SLRE_OP_LENGTH : SLRE_OP_RIGHT, k == 2 ? 16'hFFF0 : 16'h0010,
          k == 0 ? 16'h000C : (k == 3 ? 16'h0004 : 16'h8000),
          k == 3 ? 16'hFFFF : 16'h0100, k == 1);
      chk(16'(eflag), 16'(k != 1));
      chk(ecode, SLRE_ERR_STRING);
      chk(mem_u.mem[256], 16'hEEEE);
    end
    chk(mem_u.mem[16'hFFFF], 16'h3131);
    $display("error tests done");
    for (int i = 16'h1000; i < 16'h1000 + 16400; i++) mem_u.mem[i] = 16'h4141;
    run(SLRE_OP_LENGTH, 16'h1000, 16'h0000, 16'h0100, 1'b0);
    chk(16'(eflag), 16'h0001);
    chk(mem_u.mem[256], 16'hEEEE);
    $display("length limit test done");
    // pulse form holds en high: one run; continuous form: repeated runs
    for (int f = 1; f >= 0; f--) begin
      @(posedge mclk_i);
      pform <= f[0];
      op <= SLRE_OP_LENGTH;
      src <= 16'h0010;
      en <= 1;
      ndone = 0;
      repeat (60) begin
        @(posedge mclk_i);
        if (done === 1'b1) ndone++;
      end
      chk(16'(eno), 16'h0001);
      chk(16'(ndone > 1), 16'(f == 0));
      en <= 0;
      repeat (20) @(posedge mclk_i);
      chk(16'(eno), 16'h0000);
    end
    $display("execution form test done");
    wrap_up();
  end
endmodule
